// ### verif/branch_skip_load_exec_tb.sv
`timescale 1ns/1ns
module branch_skip_load_exec_tb
    import bsle_pkg::*;
;
    logic        ref_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0]  avs_address = 8'h00, mem_rdata, io_rdata, f;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
    logic [3:0]  avs_byteenable = 4'hf;
    logic [4:0]  io_addr;
    logic        avs_waitrequest;
    mem_req_t    mem_req;
    int          n_mismatch = 0, compares = 0, ticks = 0;
    branch_skip_load_exec u_branch_skip_load_exec (.ref_clk, .rst_n, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
        .mem_req, .mem_rdata, .io_addr, .io_rdata);
    mem_io_model u_mem_io_model (.ref_clk, .rst_n, .mem_req, .io_addr, .mem_rdata, .io_rdata);
    initial forever #10 ref_clk = ~ref_clk;
    // ****************
    // Bus tasks
    // ****************
    task close_out;
        if (n_mismatch == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Request held until waitrequest seen low; an idle edge follows so strobes never re-rise
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        avs_address   <= a;
        avs_writedata <= wd;
        avs_write     <= w;
        avs_read      <= !w;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge ref_clk);
    endtask
    task ex(input logic [15:0] ins, input logic [15:0] nx, input logic [7:0] pc,
            input logic [1:0] cy);
        bus(1'b1, 8'h90, 32'h0);
        bus(1'b1, 8'h80, {16'h0, ins});
        bus(1'b1, 8'h84, {16'h0, nx});
        bus(1'b1, 8'h88, 32'h1);
        do bus(1'b0, 8'h8c, 32'h0); while (d[1] !== 1'b1);
        bus(1'b1, 8'h8c, 32'h2);
        bus(1'b0, 8'h90, 32'h0);
        chk("pc", d, {24'h0, pc});
        bus(1'b0, 8'h98, 32'h0);
        chk("cycles", d, {30'h0, cy});
    endtask
    // Hang guard, far above the roughly 1300 cycles the run needs
    always @(posedge ref_clk) begin
        ticks++;
        if (ticks == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ****************
    // Scenarios
    // ****************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        ex(16'hea05, 16'h0, 8'h01, 2'd1);
        bus(1'b1, 8'h94, 32'h0);
        ex(16'h3a05, 16'h0, 8'h01, 2'd1);
        bus(1'b0, 8'h40, 32'h0);
        chk("r16", d, 32'ha5);
        // Clear skip over a one-word follower, set skip over a two-word one
        ex(16'hfd01, 16'h0, 8'h02, 2'd2);
        ex(16'hff00, 16'h9000, 8'h03, 2'd3);
        ex(16'hff01, 16'h0, 8'h01, 2'd1);
        ex(16'h9928, 16'h0, 8'h02, 2'd2);
        ex(16'h9b29, 16'h9000, 8'h03, 2'd3);
        ex(16'h9b28, 16'h0, 8'h01, 2'd1);
        bus(1'b0, 8'h94, 32'h0);
        chk("flags", d, 32'h02);
        ex(16'h2e40, 16'h0, 8'h01, 2'd1);
        bus(1'b1, 8'h68, 32'h20);
        bus(1'b1, 8'h6c, 32'h01);
        bus(1'b1, 8'h70, 32'h40);
        bus(1'b1, 8'h74, 32'h01);
        ex(16'h900d, 16'h0, 8'h01, 2'd2);
        bus(1'b0, 8'h68, 32'h0);
        chk("x_low", d, 32'h21);
        ex(16'h901e, 16'h0, 8'h01, 2'd2);
        bus(1'b0, 8'h04, 32'h0);
        chk("r1", d, 32'h7a);
        ex(16'h802b, 16'h0, 8'h01, 2'd2);
        bus(1'b0, 8'h70, 32'h0);
        chk("y_low", d, 32'h40);
        ex(16'h9030, 16'h0345, 8'h02, 2'd2);
        bus(1'b0, 8'h0c, 32'h0);
        chk("r3", d, 32'h1f);
        ex(16'h0130, 16'h0, 8'h01, 2'd1);
        bus(1'b0, 8'h18, 32'h0);
        chk("r6", d, 32'h7a);
        // Signed index tests N xor V, so N alone stands for less-than there
        for (int s = 0; s < 8; s++) begin
            f = (s == 4) ? 8'h04 : (8'h01 << s);
            bus(1'b1, 8'h94, {24'h0, f});
            ex({13'h1e03, 3'(s)}, 16'h0, 8'h04, 2'd2);
            ex({13'h1e83, 3'(s)}, 16'h0, 8'h01, 2'd1);
            // Cleared flags flip both variants; at the signed index N xor V is zero
            bus(1'b1, 8'h94, 32'h0);
            ex({13'h1e83, 3'(s)}, 16'h0, 8'h04, 2'd2);
            ex({13'h1e03, 3'(s)}, 16'h0, 8'h01, 2'd1);
        end
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", d, 32'h0);
        close_out();
    end
endmodule

// ### verif/mem_io_model.sv
`timescale 1ns/1ns
// ****************
// Memory and I/O side
// ****************
module mem_io_model
    import bsle_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire mem_req_t   mem_req,
    input  wire logic [4:0] io_addr,
    output logic [7:0]      mem_rdata,
    output logic [7:0]      io_rdata
);
    logic [7:0] last_reg;
    logic       held_reg;
    // Byte stays one cycle past the request, then flips every cycle, so stale data matches only every other cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_reg <= 1'b0;
            last_reg <= 8'h00;
        end else begin
            held_reg <= mem_req.rd;
            last_reg <= mem_rdata;
        end
    end
    // Data depends on address, so a wrong pointer shows
    assign mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ 8'h5a)
                                  : (held_reg ? last_reg : ~last_reg);
    assign io_rdata  = {io_addr, 3'b010};
endmodule

// ### verilog/branch_skip_load_exec.sv
`timescale 1ns/1ns
`include "bsle_params.svh"
module branch_skip_load_exec
    import bsle_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    output mem_req_t         mem_req,
    input  wire logic [7:0]  mem_rdata,
    output logic [4:0]       io_addr,
    input  wire logic [7:0]  io_rdata
);
    // ****************************************************************
    // Storage
    // ****************************************************************
    logic [7:0]  rf_reg [32];
    logic [7:0]  rf_next [32];
    logic [15:0] instr_reg;
    logic [15:0] next_word_reg;
    logic [15:0] pc_reg;
    logic [7:0]  flags_reg;
    logic [1:0]  cycles_reg;
    logic [1:0]  cnt_reg;
    logic [4:0]  ld_dst_reg;
    logic [4:0]  io_addr_reg;
    logic [31:0] readdata_reg;
    logic        wait_reg;
    logic        go_reg;
    logic        done_reg;
    logic        bad_reg;
    mem_req_t    mem_req_reg;
    exec_state_t state_reg;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    logic        idle;
    logic        fire;
    logic        rd_take;
    logic        wr_acc;
    logic        hit_gpr;
    logic        wr_gpr;
    logic        wr_instr;
    logic        wr_next;
    logic        wr_pc;
    logic        wr_flags;
    logic        go_set;
    logic        done_clr;
    logic        bad_clr;
    logic        busy;
    logic [31:0] rd_mux;

    // Software may only touch core state while nothing executes
    assign idle     = (state_reg == ST_IDLE) & ~go_reg;
    assign fire     = go_reg & (state_reg == ST_IDLE);
    assign busy     = ~idle;
    assign rd_take  = avs_read & wait_reg;
    assign wr_acc   = avs_write & ~wait_reg;
    assign hit_gpr  = ~avs_address[7];
    assign wr_gpr   = wr_acc & hit_gpr & idle & avs_byteenable[0];
    assign wr_instr = wr_acc & (avs_address == `OFS_INSTR) & idle;
    assign wr_next  = wr_acc & (avs_address == `OFS_NEXT_WORD) & idle;
    assign wr_pc    = wr_acc & (avs_address == `OFS_PC) & idle;
    assign wr_flags = wr_acc & (avs_address == `OFS_FLAGS) & idle & avs_byteenable[0];
    assign go_set   = wr_acc & (avs_address == `OFS_CTRL) & idle & avs_byteenable[0]
                    & avs_writedata[`CTRL_GO_BIT];
    assign done_clr = wr_acc & (avs_address == `OFS_STATUS) & avs_byteenable[0]
                    & avs_writedata[`ST_DONE_BIT];
    assign bad_clr  = wr_acc & (avs_address == `OFS_STATUS) & avs_byteenable[0]
                    & avs_writedata[`ST_BAD_BIT];

    // Read selection; unmapped words read as zero
    assign rd_mux = hit_gpr ? {24'h0, rf_reg[avs_address[6:2]]} :
        (avs_address == `OFS_INSTR)     ? {16'h0, instr_reg} :
        (avs_address == `OFS_NEXT_WORD) ? {16'h0, next_word_reg} :
        (avs_address == `OFS_STATUS)    ? {29'h0, bad_reg, done_reg, busy} :
        (avs_address == `OFS_PC)        ? {16'h0, pc_reg} :
        (avs_address == `OFS_FLAGS)     ? {24'h0, flags_reg} :
        (avs_address == `OFS_CYCLES)    ? {30'h0, cycles_reg} : 32'h0;

    // One wait cycle per access; read data is latched as the wait drops
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_reg     <= 1'b1;
            readdata_reg <= 32'h0;
        end else begin
            wait_reg     <= ~((avs_read | avs_write) & wait_reg);
            if (rd_take) begin
                readdata_reg <= rd_mux;
            end
        end
    end

    // ****************************************************************
    // Instruction decode
    // ****************************************************************
    logic [15:0] ins;
    logic [4:0]  d5;
    logic [4:0]  r5;
    logic [4:0]  dh;
    logic [7:0]  imm8;
    logic [7:0]  dh_val;
    logic [7:0]  rr_val;
    logic [3:0]  ld_mode;
    logic [5:0]  q6;
    logic [6:0]  k7;
    logic        is_cpi;
    logic        is_ldi;
    logic        is_mov;
    logic        is_register_pair_copy;
    logic        is_sbr;
    logic        is_sbi;
    logic        is_brb;
    logic        is_ldgrp;
    logic        is_lds;
    logic        is_ldd;
    logic        is_load;
    logic        predec;
    logic        postinc;
    logic        reg_bit;
    logic        io_bit;
    logic        skip_hit;
    logic        next_two;
    logic        br_taken;
    logic        illegal;

    assign ins      = instr_reg;
    assign d5       = ins[8:4];
    assign r5       = {ins[9], ins[3:0]};
    assign dh       = {1'b1, ins[7:4]};
    assign imm8     = {ins[11:8], ins[3:0]};
    assign dh_val   = rf_reg[dh];
    assign rr_val   = rf_reg[r5];
    assign ld_mode  = ins[3:0];
    assign q6       = {ins[13], ins[11:10], ins[2:0]};
    assign k7       = ins[9:3];
    assign is_cpi   = ins[15:12] == 4'h3;
    assign is_ldi   = ins[15:12] == 4'he;
    assign is_mov   = ins[15:10] == 6'h0b;
    assign is_register_pair_copy  = ins[15:8] == 8'h01;
    assign is_sbr   = (ins[15:10] == 6'h3f) & ~ins[3];
    assign is_sbi   = (ins[15:10] == 6'h26) & ins[8];
    assign is_brb   = ins[15:11] == 5'h1e;
    assign is_ldgrp = ins[15:9] == 7'h48;
    assign is_ldd   = (ins[15:14] == 2'b10) & ~ins[12] & ~ins[9];
    assign is_lds   = is_ldgrp & (ld_mode == 4'h0);
    // Modes 0,1,2,9,a,c,d,e belong here; the others are other instruction kinds
    assign is_load  = is_ldd | (is_ldgrp & (ld_mode[1:0] != 2'b11)
                    & (ld_mode[3:2] != 2'b01) & ~(ld_mode == 4'h8));
    assign predec   = is_ldgrp & (ld_mode[1:0] == 2'b10) & is_load;
    assign postinc  = is_ldgrp & (ld_mode[1:0] == 2'b01) & is_load;
    assign illegal  = ~(is_cpi | is_ldi | is_mov | is_register_pair_copy | is_sbr | is_sbi
                    | is_brb | is_load);

    // Length of the word that a skip jumps over: two-word loads, stores, jumps, calls
    assign next_two = (((next_word_reg[15:10] == 6'h24) & (next_word_reg[3:0] == 4'h0))
                    | ((next_word_reg[15:9] == 7'h4a) & (next_word_reg[3:2] == 2'b11)));

    // ****************************************************************
    // Compare, skip and branch conditions
    // ****************************************************************
    logic [7:0]  cmp_res;
    logic        cmp_h;
    logic        cmp_v;
    logic        cmp_c;
    logic [7:0]  cmp_flags;

    // Result only feeds flags; the register is never written back
    assign cmp_res   = dh_val - imm8;
    assign cmp_h     = (~dh_val[3] & imm8[3]) | (imm8[3] & cmp_res[3]) | (cmp_res[3] & ~dh_val[3]);
    assign cmp_v     = (dh_val[7] & ~imm8[7] & ~cmp_res[7]) | (~dh_val[7] & imm8[7] & cmp_res[7]);
    assign cmp_c     = (~dh_val[7] & imm8[7]) | (imm8[7] & cmp_res[7]) | (cmp_res[7] & ~dh_val[7]);
    assign cmp_flags = {flags_reg[7:6], cmp_h, cmp_res[7] ^ cmp_v, cmp_v, cmp_res[7],
                        cmp_res == 8'h00, cmp_c};

    // Skip fires when the tested bit equals the set/clear selector bit
    assign reg_bit  = rr_val[ins[2:0]];
    assign io_bit   = io_rdata[ins[2:0]];
    assign skip_hit = (is_sbr & (reg_bit == ins[9]))
                    | (is_sbi & (io_bit == ins[9]));

    flag_test u_flag_test (
        .flags    (flags_reg),
        .sel      (ins[2:0]),
        .want_set (~ins[10]),
        .taken    (br_taken)
    );

    // ****************************************************************
    // Next pc, addresses and cycle cost
    // ****************************************************************
    logic [15:0] pc_next;
    logic [15:0] br_target;
    logic [4:0]  ptr_base;
    logic [4:0]  ptr_hi;
    logic [15:0] ptr_val;
    logic [15:0] ptr_dec;
    logic [15:0] ptr_inc;
    logic [15:0] ld_addr;
    logic [1:0]  cyc;

    assign br_target = pc_reg + {{9{k7[6]}}, k7} + 16'h1;
    assign pc_next   = (is_brb & br_taken) ? br_target :
                       skip_hit ? pc_reg + (next_two ? 16'h3 : 16'h2) :
                       is_lds ? pc_reg + 16'h2 : pc_reg + 16'h1;
    // Skip costs 1, 2 or 3; branch 1 or 2; loads 2; the rest 1
    assign cyc = is_load ? `CYC_TWO :
                 (is_brb & br_taken) ? `CYC_TWO :
                 skip_hit ? (next_two ? `CYC_THREE : `CYC_TWO) : `CYC_ONE;

    assign ptr_base = is_ldd ? (ins[3] ? `PTR_Y : `PTR_Z) :
                      (ld_mode[3:2] == 2'b11) ? `PTR_X :
                      ld_mode[3] ? `PTR_Y : `PTR_Z;
    assign ptr_hi   = {ptr_base[4:1], 1'b1};
    assign ptr_val  = {rf_reg[ptr_hi], rf_reg[ptr_base]};
    assign ptr_dec  = ptr_val - 16'h1;
    assign ptr_inc  = ptr_val + 16'h1;
    assign ld_addr  = is_lds ? next_word_reg :
                      is_ldd ? ptr_val + {10'h0, q6} :
                      predec ? ptr_dec : ptr_val;

    // ****************************************************************
    // Register file
    // ****************************************************************
    // Pointer updates land at issue; the loaded byte lands one cycle later
    always_comb begin
        rf_next = rf_reg;
        if (wr_gpr) begin
            rf_next[avs_address[6:2]] = avs_writedata[7:0];
        end
        if (fire) begin
            if (is_ldi) begin
                rf_next[dh] = imm8;
            end
            if (is_mov) begin
                rf_next[d5] = rr_val;
            end
            if (is_register_pair_copy) begin
                rf_next[{ins[7:4], 1'b0}] = rf_reg[{ins[3:0], 1'b0}];
                rf_next[{ins[7:4], 1'b1}] = rf_reg[{ins[3:0], 1'b1}];
            end
            if (predec) begin
                rf_next[ptr_hi]   = ptr_dec[15:8];
                rf_next[ptr_base] = ptr_dec[7:0];
            end
            if (postinc) begin
                rf_next[ptr_hi]   = ptr_inc[15:8];
                rf_next[ptr_base] = ptr_inc[7:0];
            end
        end
        if (state_reg == ST_LOAD) begin
            rf_next[ld_dst_reg] = mem_rdata;
        end
    end

    // One flop bank per register
    for (genvar i = 0; i < 32; i++) begin : g_rf
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                rf_reg[i] <= `RST_GPR;
            end else begin
                rf_reg[i] <= rf_next[i];
            end
        end
    end

    // ****************************************************************
    // Software-visible words and core state
    // ****************************************************************
    // Merged instruction word; the I/O index is its operand field, bits 7 to 3
    logic [15:0] instr_wr;
    assign instr_wr = merge16(instr_reg, avs_writedata, avs_byteenable);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            instr_reg     <= `RST_WORD;
            next_word_reg <= `RST_WORD;
            io_addr_reg   <= 5'h00;
        end else begin
            if (wr_instr) begin
                instr_reg   <= instr_wr;
                io_addr_reg <= instr_wr[7:3];
            end
            if (wr_next) begin
                next_word_reg <= merge16(next_word_reg, avs_writedata, avs_byteenable);
            end
        end
    end

    // Only compare touches flags; branches, skips and loads leave them
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_reg    <= `RST_PC;
            flags_reg <= `RST_FLAGS;
        end else if (fire) begin
            pc_reg    <= pc_next;
            flags_reg <= is_cpi ? cmp_flags : flags_reg;
        end else begin
            pc_reg    <= wr_pc ? merge16(pc_reg, avs_writedata, avs_byteenable) : pc_reg;
            flags_reg <= wr_flags ? avs_writedata[7:0] : flags_reg;
        end
    end

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    logic finish;
    assign finish = (fire & ~is_load & (cyc == `CYC_ONE))
                  | ((state_reg == ST_HOLD) & (cnt_reg == 2'd1))
                  | (state_reg == ST_LOAD);

    // Hold state pads out the cycles the instruction is charged
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg   <= 2'd0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (fire) begin
                        state_reg <= is_load ? ST_LOAD :
                                     (cyc == `CYC_ONE) ? ST_IDLE : ST_HOLD;
                        cnt_reg   <= cyc - 2'd1;
                    end
                end
                ST_HOLD: begin
                    state_reg <= (cnt_reg == 2'd1) ? ST_IDLE : ST_HOLD;
                    cnt_reg   <= cnt_reg - 2'd1;
                end
                ST_LOAD: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Memory strobe is a single cycle; the byte is taken in that same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mem_req_reg <= '0;
            ld_dst_reg  <= 5'h00;
        end else begin
            mem_req_reg.rd <= fire & is_load;
            if (fire & is_load) begin
                mem_req_reg.addr <= ld_addr;
                ld_dst_reg       <= d5;
            end
        end
    end

    // Set wins over a clear arriving in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            go_reg     <= 1'b0;
            done_reg   <= 1'b0;
            bad_reg    <= 1'b0;
            cycles_reg <= 2'd0;
        end else begin
            go_reg     <= go_set;
            done_reg   <= finish | (done_reg & ~done_clr);
            bad_reg    <= (fire & illegal) | (bad_reg & ~bad_clr);
            cycles_reg <= fire ? cyc : cycles_reg;
        end
    end

    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = wait_reg;
    assign mem_req         = mem_req_reg;
    assign io_addr         = io_addr_reg;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence back_idle;
        state_reg == ST_IDLE;
    endsequence
    sequence held_one;
        state_reg == ST_HOLD ##1 state_reg == ST_IDLE;
    endsequence
    sequence held_two;
        state_reg == ST_HOLD [*2] ##1 state_reg == ST_IDLE;
    endsequence

    cmp_flags_only_a: assert property (fire && is_cpi |=> back_idle
        ##0 flags_reg[`FLAG_Z] == ($past(dh_val) == $past(imm8))
        ##0 rf_reg[$past(dh)] == $past(dh_val)) else $error("compare altered register");
    skip_reg_clear_a: assert property (fire && is_sbr && !ins[9] && !reg_bit
        && !next_two |=> pc_reg == $past(pc_reg) + 16'h2 ##0 held_one)
        else $error("register bit clear skip wrong");
    skip_reg_set_a: assert property (fire && is_sbr && ins[9] && reg_bit
        && next_two |=> pc_reg == $past(pc_reg) + 16'h3 ##0 held_two)
        else $error("register bit set skip wrong");
    skip_io_clear_a: assert property (fire && is_sbi && !ins[9] && !io_bit
        |=> flags_reg == $past(flags_reg)
        ##0 pc_reg - $past(pc_reg) == ($past(next_two) ? 16'h3 : 16'h2))
        else $error("io bit clear skip wrong");
    skip_io_miss_a: assert property (fire && is_sbi && ins[9] && !io_bit
        |=> back_idle ##0 pc_reg == $past(pc_reg) + 16'h1
        ##0 flags_reg == $past(flags_reg)) else $error("io bit set skip wrong");
    branch_taken_a: assert property (fire && is_brb && br_taken
        |=> pc_reg == $past(pc_reg) + 16'($signed($past(k7))) + 16'h1 ##0 held_one)
        else $error("taken branch target or timing wrong");
    branch_signed_a: assert property (fire && is_brb && ins[2:0] == 3'd4
        |-> br_taken == (ins[10] ^ (flags_reg[`FLAG_N] ^ flags_reg[`FLAG_V])))
        else $error("signed branch condition wrong");
    branch_flag_a: assert property (
        fire && is_brb && ins[2:0] != 3'd4
        |-> br_taken == (flags_reg[ins[2:0]] == ~ins[10])) else $error("flag branch wrong");
    load_two_cycle_a: assert property (fire && is_load |=> state_reg == ST_LOAD
        && mem_req_reg.rd && mem_req_reg.addr == $past(ld_addr)
        ##1 back_idle ##0 rf_reg[$past(d5, 2)] == $past(mem_rdata))
        else $error("load did not finish in two cycles");
    predec_addr_a: assert property (fire && predec
        |=> mem_req_reg.addr == $past(ptr_val) - 16'h1
        ##0 {rf_reg[$past(ptr_hi)], rf_reg[$past(ptr_base)]} == mem_req_reg.addr)
        else $error("pre-decrement address wrong");
    disp_addr_a: assert property (fire && is_ldd
        |=> mem_req_reg.addr == $past(ptr_val) + {10'h0, $past(q6)}
        ##0 {rf_reg[$past(ptr_hi)], rf_reg[$past(ptr_base)]} == $past(ptr_val))
        else $error("displacement load wrong");
    direct_addr_a: assert property (fire && is_lds
        |=> mem_req_reg.addr == $past(next_word_reg) ##0 flags_reg == $past(flags_reg)
        ##0 pc_reg == $past(pc_reg) + 16'h2) else $error("direct load wrong");
    move_one_cycle_a: assert property (fire && (is_mov || is_register_pair_copy || is_ldi)
        |=> back_idle ##0 flags_reg == $past(flags_reg) ##0 done_reg)
        else $error("move not single cycle");
endmodule

// ### verilog/bsle_params.svh
`ifndef BSLE_PARAMS_SVH
`define BSLE_PARAMS_SVH

// Register byte offsets; general registers fill 0x00 to 0x7c
`define OFS_INSTR      8'h80
`define OFS_NEXT_WORD  8'h84
`define OFS_CTRL       8'h88
`define OFS_STATUS     8'h8c
`define OFS_PC         8'h90
`define OFS_FLAGS      8'h94
`define OFS_CYCLES     8'h98

// Field positions
`define CTRL_GO_BIT    0
`define ST_BUSY_BIT    0
`define ST_DONE_BIT    1
`define ST_BAD_BIT     2
`define FLAG_C         0
`define FLAG_Z         1
`define FLAG_N         2
`define FLAG_V         3
`define FLAG_S         4
`define FLAG_H         5
`define FLAG_T         6
`define FLAG_I         7

// Reset values
`define RST_PC         16'h0000
`define RST_FLAGS      8'h00
`define RST_GPR        8'h00
`define RST_WORD       16'h0000

// Cycle counts per instruction class
`define CYC_ONE        2'd1
`define CYC_TWO        2'd2
`define CYC_THREE      2'd3

// Pointer low register numbers
`define PTR_X          5'd26
`define PTR_Y          5'd28
`define PTR_Z          5'd30
`endif

// ### verilog/bsle_pkg.sv
package bsle_pkg;
    // Execution sequencer states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HOLD = 3'b010,
        ST_LOAD = 3'b100
    } exec_state_t;

    // Data memory read request
    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
    } mem_req_t;
endpackage

// ### verilog/flag_test.sv
`timescale 1ns/1ns
`include "bsle_params.svh"
module flag_test (
    input  wire logic [7:0] flags,
    input  wire logic [2:0] sel,
    input  wire logic       want_set,
    output logic            taken
);
    logic signed_less;
    logic picked;

    // Signed test uses live N xor V so a stale S bit cannot mislead
    assign signed_less = flags[`FLAG_N] ^ flags[`FLAG_V];
    // Any flag by index: C, Z, N, V, H, T, I
    assign picked = (sel == 3'd4) ? signed_less : flags[sel];
    // Set variant takes on one, clear variant on zero
    assign taken = want_set ? picked : ~picked;
endmodule
